// file: rtl/heat_seq_pkg.sv
// constants and carrier types for the furnace heating sequencer
// Notes on behaviour
// - pressure switch must read open before start
// - inducer is first output energized
// - ignition only after pressure switch closes
// - series pressure switch opening gives code three
// - ignitor warms 17 s before gas valve
// - short stabilization, then check flame
// - continue only while flame at least 0.1 uA
// - amber warning while flame below 1.5 uA
// - blower on 30 s after flame sensed
// - drive heating blower output during heating
// - heat call ends: gas off, blower-off timing
// - inducer runs post purge then stops
// - flame must vanish right after valve closes (code checks flame once, one second after the valve closes)
// - blower-off delay chosen by jumper input
// - flash codes: 1/3 s pulses, 2 s gap
package heat_seq_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int SEC_TIME_S = 1;
    localparam int SEC_CYC = CLK_HZ * SEC_TIME_S;
    localparam int FLASH_DIV = 3;
    localparam int THIRD_CYC = (CLK_HZ + FLASH_DIV - 1) / FLASH_DIV;
    localparam int WARMUP_S = 17;
    localparam int BLOWER_ON_S = 30;
    localparam int STAB_S = 3;
    localparam int POST_PURGE_S = 5;
    localparam int PS_WAIT_S = 10;
    localparam int GAP_S = 2;
    localparam int GAP_THIRDS = GAP_S * FLASH_DIV;
    localparam logic [7:0] BOFF_S0 = 8'h3C;
    localparam logic [7:0] BOFF_S1 = 8'h5A;
    localparam logic [7:0] BOFF_S2 = 8'h78;
    localparam logic [7:0] BOFF_S3 = 8'hB4;
    // ------------------------------------------------------------
    // flame current, tenths of a microamp
    // ------------------------------------------------------------
    localparam logic [7:0] FLAME_MIN = 8'h01;
    localparam logic [7:0] FLAME_WEAK = 8'h0F;
    // ------------------------------------------------------------
    // fault codes
    // ------------------------------------------------------------
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_FLAME_NOCALL = 4'h1;
    localparam logic [3:0] FC_PS_STUCK = 4'h2;
    localparam logic [3:0] FC_PS_OPEN = 4'h3;
    localparam logic [3:0] FC_NO_LIGHT = 4'h7;
    localparam logic [3:0] FC_FLAME_LOST = 4'h8;

    typedef struct packed {
        logic heat_call;
        logic press_closed;
        logic [7:0] flame_ua;
    } pins_t;

    typedef struct packed {
        logic inducer;
        logic ignitor;
        logic gas_valve;
        logic blower;
    } acts_t;

    typedef enum logic [2:0] {
        S_IDLE, S_PRECHK, S_INDUCE, S_WARMUP, S_STAB, S_RUN, S_SHUT
    } state_t;
endpackage : heat_seq_pkg

// file: rtl/furnace_heating_sequencer.sv
// heating sequencer: call for heat through ignition, run and shutdown
`timescale 1ns/1ps
`default_nettype none
module furnace_heating_sequencer #(
    parameter int SEC_CYC = heat_seq_pkg::SEC_CYC,
    parameter int THIRD_CYC = heat_seq_pkg::THIRD_CYC,
    parameter int STAB_S = heat_seq_pkg::STAB_S,
    parameter int POST_PURGE_S = heat_seq_pkg::POST_PURGE_S
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // field inputs
    input wire heat_seq_pkg::pins_t pins_i,
    input wire logic [1:0] boff_sel_i,
    // actuators
    output var heat_seq_pkg::acts_t acts_o,
    // status
    output logic led_red_o,
    output logic led_green_o,
    output logic led_amber_o,
    output logic [3:0] fault_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    heat_seq_pkg::pins_t s1_q, s2_q, s3_q, pins_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pins_q <= '0;
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // multi-bit flame reading only accepted once settled
            if (s2_q == s3_q) begin
                pins_q <= s3_q;
            end
        end
    end

    wire logic flame_ok = (pins_q.flame_ua >= heat_seq_pkg::FLAME_MIN);
    wire logic flame_weak = (pins_q.flame_ua < heat_seq_pkg::FLAME_WEAK);

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    heat_seq_pkg::state_t state_q, state_d;
    logic [7:0] sec_q;
    logic [25:0] sdiv_q;
    logic sec_tick;
    logic [3:0] fault_q, fault_d;

    assign sec_tick = (sdiv_q == 26'(SEC_CYC - 1));

    always_comb begin
        state_d = state_q;
        fault_d = fault_q;
        case (state_q)
            heat_seq_pkg::S_IDLE: begin
                if (pins_q.heat_call) begin
                    state_d = heat_seq_pkg::S_PRECHK;
                end else if (flame_ok) begin
                    fault_d = heat_seq_pkg::FC_FLAME_NOCALL;
                end
            end
            heat_seq_pkg::S_PRECHK: begin
                if (!pins_q.heat_call) begin
                    state_d = heat_seq_pkg::S_IDLE;
                end else if (pins_q.press_closed) begin
                    fault_d = heat_seq_pkg::FC_PS_STUCK;
                end else begin
                    fault_d = heat_seq_pkg::FC_NONE;
                    state_d = heat_seq_pkg::S_INDUCE;
                end
            end
            heat_seq_pkg::S_INDUCE: begin
                if (!pins_q.heat_call) begin
                    state_d = heat_seq_pkg::S_SHUT;
                end else if (pins_q.press_closed) begin
                    state_d = heat_seq_pkg::S_WARMUP;
                end else if (sec_tick && sec_q == 8'(heat_seq_pkg::PS_WAIT_S - 1)) begin
                    fault_d = heat_seq_pkg::FC_PS_OPEN;
                    state_d = heat_seq_pkg::S_SHUT;
                end
            end
            heat_seq_pkg::S_WARMUP, heat_seq_pkg::S_STAB, heat_seq_pkg::S_RUN: begin
                if (!pins_q.heat_call) begin
                    state_d = heat_seq_pkg::S_SHUT;
                end else if (!pins_q.press_closed) begin
                    fault_d = heat_seq_pkg::FC_PS_OPEN;
                    state_d = heat_seq_pkg::S_SHUT;
                end else if (state_q == heat_seq_pkg::S_WARMUP) begin
                    if (sec_tick && sec_q == 8'(heat_seq_pkg::WARMUP_S - 1)) begin
                        state_d = heat_seq_pkg::S_STAB;
                    end
                end else if (state_q == heat_seq_pkg::S_STAB) begin
                    if (sec_tick && sec_q == 8'(STAB_S - 1)) begin
                        if (flame_ok) begin
                            state_d = heat_seq_pkg::S_RUN;
                        end else begin
                            fault_d = heat_seq_pkg::FC_NO_LIGHT;
                            state_d = heat_seq_pkg::S_SHUT;
                        end
                    end
                end else if (!flame_ok) begin
                    fault_d = heat_seq_pkg::FC_FLAME_LOST;
                    state_d = heat_seq_pkg::S_SHUT;
                end
            end
            heat_seq_pkg::S_SHUT: begin
                // flame still present one second after valve closed
                if (sec_tick && sec_q == 8'h00 && flame_ok) begin
                    fault_d = heat_seq_pkg::FC_FLAME_NOCALL;
                end
                if (sec_tick && sec_q == 8'(POST_PURGE_S - 1)) begin
                    state_d = heat_seq_pkg::S_IDLE;
                end
            end
            default: state_d = heat_seq_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= heat_seq_pkg::S_IDLE;
            fault_q <= heat_seq_pkg::FC_NONE;
        end else begin
            state_q <= state_d;
            fault_q <= fault_d;
        end
    end

    // ------------------------------------------------------------
    // one-second timer, restarted on every state change
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdiv_q <= '0;
            sec_q <= '0;
        end else if (state_d != state_q) begin
            sdiv_q <= '0;
            sec_q <= '0;
        end else if (sec_tick) begin
            sdiv_q <= '0;
            sec_q <= (sec_q == 8'hFF) ? sec_q : sec_q + 8'h01;
        end else begin
            sdiv_q <= sdiv_q + 26'h0000001;
        end
    end

    // ------------------------------------------------------------
    // blower-off delay runs alongside post purge
    // ------------------------------------------------------------
    logic [7:0] boff_q;
    logic [25:0] bdiv_q;
    logic blower_run;
    assign blower_run = (state_q == heat_seq_pkg::S_RUN)
        && (sec_q >= 8'(heat_seq_pkg::BLOWER_ON_S));

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boff_q <= '0;
            bdiv_q <= '0;
        end else if (blower_run && state_d != heat_seq_pkg::S_RUN) begin
            bdiv_q <= '0;
            case (boff_sel_i)
                2'h0: boff_q <= heat_seq_pkg::BOFF_S0;
                2'h1: boff_q <= heat_seq_pkg::BOFF_S1;
                2'h2: boff_q <= heat_seq_pkg::BOFF_S2;
                default: boff_q <= heat_seq_pkg::BOFF_S3;
            endcase
        end else if (boff_q != 8'h00) begin
            if (bdiv_q == 26'(SEC_CYC - 1)) begin
                bdiv_q <= '0;
                boff_q <= boff_q - 8'h01;
            end else begin
                bdiv_q <= bdiv_q + 26'h0000001;
            end
        end
    end

    // ------------------------------------------------------------
    // actuators
    // ------------------------------------------------------------
    heat_seq_pkg::acts_t acts_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acts_q <= '0;
        end else begin
            acts_q.inducer <= (state_d == heat_seq_pkg::S_INDUCE)
                || (state_d == heat_seq_pkg::S_WARMUP) || (state_d == heat_seq_pkg::S_STAB)
                || (state_d == heat_seq_pkg::S_RUN) || (state_d == heat_seq_pkg::S_SHUT);
            acts_q.ignitor <= (state_d == heat_seq_pkg::S_WARMUP)
                || (state_d == heat_seq_pkg::S_STAB);
            acts_q.gas_valve <= (state_d == heat_seq_pkg::S_STAB)
                || (state_d == heat_seq_pkg::S_RUN);
            // blower_run still holds on the edge that loads the off delay,
            // so the blower sees no one-cycle dip at the end of the call
            acts_q.blower <= blower_run || (boff_q != 8'h00);
        end
    end
    assign acts_o = acts_q;
    assign fault_o = fault_q;

    // ------------------------------------------------------------
    // status led: codes, weak flame, heat call, standby
    // ------------------------------------------------------------
    logic [23:0] tdiv_q;
    logic [4:0] fl_q;
    logic slow_q, red_q, grn_q, amb_q;
    wire logic third_tick = (tdiv_q == 24'(THIRD_CYC - 1));
    wire logic [4:0] fl_len = {fault_q, 1'b0} + 5'(heat_seq_pkg::GAP_THIRDS);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tdiv_q <= '0;
            fl_q <= '0;
            slow_q <= 1'b0;
        end else if (third_tick) begin
            tdiv_q <= '0;
            fl_q <= (fl_q >= fl_len - 5'h01) ? 5'h00 : fl_q + 5'h01;
            if (fl_q[1:0] == 2'h2 || fl_q == fl_len - 5'h01) begin
                slow_q <= ~slow_q;
            end
        end else begin
            tdiv_q <= tdiv_q + 24'h000001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            red_q <= 1'b0;
            grn_q <= 1'b0;
            amb_q <= 1'b0;
        end else begin
            // dark gap is the tail of the count, after 2n thirds
            red_q <= (fault_q != heat_seq_pkg::FC_NONE)
                && (fl_q < {fault_q, 1'b0}) && !fl_q[0];
            grn_q <= (fault_q == heat_seq_pkg::FC_NONE) && !pins_q.heat_call && slow_q;
            if (fault_q != heat_seq_pkg::FC_NONE || !pins_q.heat_call) begin
                amb_q <= 1'b0;
            end else if (state_q == heat_seq_pkg::S_RUN && flame_weak) begin
                amb_q <= !fl_q[0];
            end else begin
                amb_q <= slow_q;
            end
        end
    end
    assign led_red_o = red_q;
    assign led_green_o = grn_q;
    assign led_amber_o = amb_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_no_start_closed: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == heat_seq_pkg::S_PRECHK && pins_q.press_closed
        |=> state_q != heat_seq_pkg::S_INDUCE)
        else $error("sequence started with pressure switch closed");
    a_inducer_first: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(acts_o.ignitor) |-> acts_o.inducer && $past(acts_o.inducer))
        else $error("ignitor before inducer");
    a_ign_needs_press: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(acts_o.ignitor) |-> $past(pins_q.press_closed))
        else $error("ignition without pressure proof");
    a_press_open_code: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acts_o.gas_valve && pins_q.heat_call && !pins_q.press_closed
        |=> fault_q == heat_seq_pkg::FC_PS_OPEN ##1 !acts_o.gas_valve)
        else $error("pressure loss not handled");
    a_warmup_length: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(acts_o.gas_valve) |-> $past(state_q) == heat_seq_pkg::S_WARMUP
        && $past(sec_q) == 8'(heat_seq_pkg::WARMUP_S - 1))
        else $error("gas valve opened before warm-up end");
    a_low_flame_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == heat_seq_pkg::S_RUN && !flame_ok |=> ##1 !acts_o.gas_valve)
        else $error("gas kept open without flame");
    a_blower_delay: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(acts_o.blower) |-> $past(sec_q) >= 8'(heat_seq_pkg::BLOWER_ON_S)
        && $past(state_q) == heat_seq_pkg::S_RUN)
        else $error("blower started before delay");
    a_gas_off_call: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        acts_o.gas_valve && !pins_q.heat_call |=> !acts_o.gas_valve)
        else $error("gas valve not closed at end of call");
    a_post_purge: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $fell(acts_o.inducer) |-> $past(state_q, 2) == heat_seq_pkg::S_SHUT)
        else $error("inducer stopped without post purge");
    a_stab_fail: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == heat_seq_pkg::S_STAB && state_d == heat_seq_pkg::S_SHUT
        |=> !acts_o.gas_valve && !acts_o.ignitor)
        else $error("failed trial left valve or ignitor on");
    a_blower_no_gap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        blower_run && state_d != heat_seq_pkg::S_RUN |=> acts_o.blower [*2])
        else $error("blower dropped when call ended");
    a_flame_after_off: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        state_q == heat_seq_pkg::S_SHUT && sec_tick && sec_q == 8'h00 && flame_ok
        |=> fault_q == heat_seq_pkg::FC_FLAME_NOCALL)
        else $error("lingering flame after valve close not flagged");
endmodule : furnace_heating_sequencer
`default_nettype wire

// file: verification/field_model.sv
// pressure switch and flame sensor model facing the sequencer actuators
`timescale 1ns/1ps
`default_nettype none
module field_model (
    // clock
    input wire logic sys_clk_i,
    // actuators seen
    input wire heat_seq_pkg::acts_t acts_i,
    // scenario controls
    input wire logic [1:0] press_mode_i,
    input wire logic [7:0] flame_lvl_i,
    input wire logic linger_i,
    // field signals
    output logic press_closed_o,
    output logic [7:0] flame_ua_o
);
    // ------------------------------------------------------------
    // behaviour
    // ------------------------------------------------------------
    logic [3:0] spin_q = 4'h0;
    logic burn_q = 1'b0;
    // switch makes only once the inducer has spun up a while
    always @(negedge sys_clk_i) begin
        if (!acts_i.inducer) spin_q <= 4'h0;
        else if (spin_q != 4'hF) spin_q <= spin_q + 4'h1;
        burn_q <= acts_i.gas_valve | (linger_i & burn_q);
    end
    // mode 1 stuck closed, mode 2 stuck open
    assign press_closed_o = (press_mode_i == 2'h1) ? 1'b1 :
                            (press_mode_i == 2'h2) ? 1'b0 : (spin_q >= 4'h8);
    // linger models a valve that leaks after closing
    assign flame_ua_o = burn_q ? flame_lvl_i : 8'h00;
endmodule : field_model
`default_nettype wire

// file: verification/furnace_heating_sequencer_tb.sv
// self-checking bench for the furnace heating sequencer
`timescale 1ns/1ps
`default_nettype none
module furnace_heating_sequencer_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int SEC = 20;
    localparam int THIRD = 7;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic call = 1'b0;
    logic [1:0] boff_sel = 2'h0;
    logic [1:0] pmode = 2'h0;
    logic [7:0] flvl = 8'h00;
    logic linger = 1'b0;
    logic press_c;
    logic [7:0] flame_w;
    heat_seq_pkg::pins_t pins;
    heat_seq_pkg::acts_t acts;
    logic red, green, amber;
    logic [3:0] fault;
    logic [4:0] mon;
    int errors = 0;
    int tests_run = 0;
    int n, m, k, i;
    logic [31:0] rnd = 32'h3E66AD1E;
    assign pins = {call, press_c, flame_w};
    assign mon = {red, acts};
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    furnace_heating_sequencer #(.SEC_CYC(SEC), .THIRD_CYC(THIRD), .STAB_S(3),
        .POST_PURGE_S(5)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pins_i(pins),
        .boff_sel_i(boff_sel), .acts_o(acts), .led_red_o(red), .led_green_o(green),
        .led_amber_o(amber), .fault_o(fault));
    field_model field (.sys_clk_i(sys_clk_i), .acts_i(acts), .press_mode_i(pmode),
        .flame_lvl_i(flvl), .linger_i(linger), .press_closed_o(press_c),
        .flame_ua_o(flame_w));
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    // counts falling edges until bit b of mon reads v
    task automatic wait_bit(input int b, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (mon[b] !== v && cnt < lim) begin
            @(negedge sys_clk_i);
            cnt++;
        end
        if (cnt >= lim) begin
            errors++;
            $display("[FAIL] %0t wait on output %0d ran out", $time, b);
            wrap_up();
        end
    endtask : wait_bit
    task automatic set_call(input logic v);
        @(negedge sys_clk_i);
        call = v;
    endtask : set_call
    // boff model: chosen jumper table entry converted to clock cycles
    function automatic int boff_cyc(input logic [1:0] s);
        case (s)
            2'h0: return int'(heat_seq_pkg::BOFF_S0) * SEC;
            2'h1: return int'(heat_seq_pkg::BOFF_S1) * SEC;
            2'h2: return int'(heat_seq_pkg::BOFF_S2) * SEC;
            default: return int'(heat_seq_pkg::BOFF_S3) * SEC;
        endcase
    endfunction : boff_cyc
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        errors++;
        $display("[FAIL] %0t run limit reached", $time);
        wrap_up();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        rnd = lfsr(rnd);
        boff_sel = rnd[1:0];
        flvl = 8'h01 + 8'(rnd[9:2] % 14);
        set_call(1'b1);
        wait_bit(3, 1'b1, 20, n);
        chk(acts.ignitor, 1'b0);
        wait_bit(2, 1'b1, 100, n);
        chk(press_c, 1'b1);
        wait_bit(1, 1'b1, 400, n);
        chk(n, 17 * SEC);
        wait_bit(2, 1'b0, 100, n);
        chk(n, 3 * SEC);
        chk(acts.gas_valve, 1'b1);
        m = 0;
        for (i = 0; i < 9 * THIRD; i++) begin
            @(negedge sys_clk_i);
            if (red !== 1'b0 || green !== 1'b0) m++;
        end
        chk(m, 0);
        k = 0;
        for (i = 0; i < 9 * THIRD; i++) begin
            m = amber;
            @(negedge sys_clk_i);
            if (amber !== m[0]) k++;
        end
        chk(k, 9);
        wait_bit(0, 1'b1, 700, n);
        // output flop adds one cycle to each blower edge
        chk(n + 18 * THIRD, 30 * SEC + 1);
        set_call(1'b0);
        wait_bit(1, 1'b0, 10, n);
        chk(n < 9, 1'b1);
        wait_bit(3, 1'b0, 200, m);
        chk(m, 5 * SEC);
        wait_bit(0, 1'b0, 4000, n);
        chk(m + n, boff_cyc(boff_sel) + 1);
        chk(fault, heat_seq_pkg::FC_NONE);
        $display("test normal cycle done");
        pmode = 2'h1;
        set_call(1'b1);
        repeat (30) @(negedge sys_clk_i);
        chk(fault, heat_seq_pkg::FC_PS_STUCK);
        chk(acts.inducer, 1'b0);
        pmode = 2'h0;
        flvl = 8'h00;
        wait_bit(3, 1'b1, 20, n);
        chk(fault, heat_seq_pkg::FC_NONE);
        wait_bit(1, 1'b1, 500, n);
        wait_bit(1, 1'b0, 100, n);
        chk(n, 3 * SEC);
        chk({acts.ignitor, fault}, {1'b0, heat_seq_pkg::FC_NO_LIGHT});
        set_call(1'b0);
        wait_bit(3, 1'b0, 300, n);
        $display("test stuck switch and no light done");
        for (k = 0; k < 3; k++) begin
            flvl = 8'h14;
            linger = (k == 2);
            repeat (10) @(negedge sys_clk_i);
            set_call(1'b1);
            wait_bit(2, 1'b1, 100, n);
            wait_bit(2, 1'b0, 500, n);
            if (k == 0) flvl = 8'h00;
            if (k == 1) pmode = 2'h2;
            if (k == 2) set_call(1'b0);
            repeat (30) @(negedge sys_clk_i);
            chk(acts.gas_valve, 1'b0);
            chk(fault, (k == 0) ? heat_seq_pkg::FC_FLAME_LOST : (k == 1) ?
                heat_seq_pkg::FC_PS_OPEN : heat_seq_pkg::FC_FLAME_NOCALL);
            if (k == 1) begin
                // drop the call so a new precheck cannot clear the code
                set_call(1'b0);
                n = 0;
                for (i = 0; i < 2000 && !(red === 1'b1 && n >= 45); i++) begin
                    @(negedge sys_clk_i);
                    n = (red === 1'b1) ? ((n >= 45) ? n : 0) : n + 1;
                end
                chk(i < 2000, 1'b1);
                for (i = 0; i < 6; i++) begin
                    wait_bit(4, i[0], 100, n);
                    chk(n, (i == 5) ? THIRD * (1 + heat_seq_pkg::GAP_THIRDS) : THIRD);
                end
            end
            linger = 1'b0;
            pmode = 2'h0;
            set_call(1'b0);
            wait_bit(3, 1'b0, 300, n);
            $display("test fault case %0d done", k);
        end
        wrap_up();
    end
endmodule : furnace_heating_sequencer_tb
`default_nettype wire
